// ---- src/snv_sequencer.sv ----
// Staging SRAM, commit, erase/program and power-on overlay sequencer
//
// Contract
// - Commit bit copies active settings into staging SRAM automatically.
// - Commit bit clears itself when the copy finishes.
// - Overlay enable bit applies nonvolatile image over start-up settings.
// - Erase and program accepted only after key 234 is written.
// - Erase and program triggers set together in one write; code also accepts the program trigger alone and then skips the erase.
// - Program trigger transfers whole staging SRAM into nonvolatile memory.
// - Busy bit readable while programming; host polls or waits 500 ms.
// - Next power-on after good program increments program tally by one.
// - At power-on with overlay set, active registers load from image.
// - Commit leaves address bits and revision fields of SRAM alone.
// - Direct SRAM writes never disturb active registers.
// - Direct SRAM writes may change address bits and revision fields.
// - SRAM loaded first; nonvolatile memory only via automatic transfer.
// - Thirteen-bit SRAM pointer: five-bit high field, eight-bit low.
// - Data register write stores byte at pointer location.
`timescale 1ns/1ps
`include "snv_params.svh"

module snv_sequencer #(
	parameter int         ACT_WORDS  = 32,
	parameter int         MEM_WORDS  = 64,
	parameter int         PROTECT_LO = 12,
	parameter int         PROTECT_HI = 13,
	parameter int unsigned BUSY_CYCLES = `SNV_BUSY_CYCLES
) (
	input  wire logic            ref_clk,
	input  wire logic            rstn,
	input  wire logic            clkEn,
	input  wire logic            porPulse,
	input  wire snv_pkg::snv_req_t regReq,
	output snv_pkg::snv_rsp_t    regRsp,
	input  wire logic            actWr,
	input  wire logic [7:0]      actAddr,
	input  wire logic [7:0]      actWdata,
	output logic [7:0]           actRdata,
	output logic                 busyOut,
	output logic                 overlayOut
);
	import snv_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam int AW  = $clog2(MEM_WORDS);
	localparam int ACW = $clog2(ACT_WORDS);
	logic [7:0]  activeMem [ACT_WORDS];
	logic [7:0]  sramMem   [MEM_WORDS];
	logic [7:0]  nvMem     [MEM_WORDS];
	snv_state_t  state_q;
	logic [12:0] ptr_q;
	logic [7:0]  unlock_q;
	logic        overlay_q;
	logic        commit_q;
	logic        eraseReq_q;
	logic [7:0]  tally_q;
	logic        progDone_q;
	logic [AW:0] idx_q;
	logic [31:0] wait_q;

	// Address compare used by every register write decode; the read mux decodes the address in its own case
	function automatic logic hit(input logic [14:0] a, input logic [14:0] ofs);
		return a == ofs;
	endfunction

	// Staging word protected from the commit path
	function automatic logic isProtected(input logic [AW:0] i);
		return (int'(i) == PROTECT_LO) || (int'(i) == PROTECT_HI);
	endfunction

	logic wrEn;
	logic ctrlWr;
	logic keyOk;
	logic busyNow;
	assign wrEn   = clkEn && regReq.wr;
	assign ctrlWr = wrEn && hit(regReq.addr, `SNV_OFS_NVCTRL);
	assign keyOk  = unlock_q == `SNV_UNLOCK_KEY;

	// Busy spans erase through settle; the commit copy shows only on its own bit
	assign busyNow = (state_q == SNV_ERASE) || (state_q == SNV_PROGRAM)
		|| (state_q == SNV_SETTLE);

	// ----------------------------------------
	// Unlock key, overlay bit, SRAM pointer
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			unlock_q  <= `SNV_RESET_BYTE;
			overlay_q <= 1'b0;
			ptr_q     <= 13'h0000;
		end else if (wrEn) begin
			if (hit(regReq.addr, `SNV_OFS_UNLOCK)) begin
				unlock_q <= regReq.wdata;
			end
			if (hit(regReq.addr, `SNV_OFS_OVERLAY)) begin
				overlay_q <= regReq.wdata[`SNV_BIT_OVERLAY];
			end
			if (hit(regReq.addr, `SNV_OFS_PTR_HIGH)) begin
				ptr_q[12:8] <= regReq.wdata[4:0];
			end
			if (hit(regReq.addr, `SNV_OFS_PTR_LOW)) begin
				ptr_q[7:0] <= regReq.wdata;
			end
		end
	end

	// ----------------------------------------
	// Sequencer: commit, erase, program
	// ----------------------------------------
	// Triggers are ignored while a sequence runs so a stray write cannot restart it
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_q    <= SNV_IDLE;
			commit_q   <= 1'b0;
			eraseReq_q <= 1'b0;
			idx_q      <= '0;
			wait_q     <= 32'h0000_0000;
			progDone_q <= 1'b0;
		end else if (clkEn) begin
			// Power-on clears first, so a program that ends in the same cycle still counts
			if (porPulse) begin
				progDone_q <= 1'b0;
			end
			unique case (state_q)
				SNV_IDLE: begin
					idx_q <= '0;
					if (ctrlWr && regReq.wdata[`SNV_BIT_COMMIT]) begin
						commit_q <= 1'b1;
						state_q  <= SNV_COMMIT;
					end else if (ctrlWr && keyOk && regReq.wdata[`SNV_BIT_PROG]) begin
						eraseReq_q <= regReq.wdata[`SNV_BIT_ERASE];
						state_q    <= regReq.wdata[`SNV_BIT_ERASE] ? SNV_ERASE : SNV_PROGRAM;
					end
				end
				SNV_COMMIT: begin
					if (int'(idx_q) == ACT_WORDS - 1 || int'(idx_q) == MEM_WORDS - 1) begin
						commit_q <= 1'b0;
						state_q  <= SNV_IDLE;
					end
					idx_q <= idx_q + 1'b1;
				end
				SNV_ERASE: begin
					if (int'(idx_q) == MEM_WORDS - 1) begin
						idx_q   <= '0;
						state_q <= SNV_PROGRAM;
					end else begin
						idx_q <= idx_q + 1'b1;
					end
				end
				SNV_PROGRAM: begin
					if (int'(idx_q) == MEM_WORDS - 1) begin
						wait_q  <= 32'h0000_0000;
						state_q <= SNV_SETTLE;
					end
					idx_q <= idx_q + 1'b1;
				end
				SNV_SETTLE: begin
					// Models the cell write time; busy stays set throughout
					if (wait_q >= BUSY_CYCLES - 1) begin
						progDone_q <= 1'b1;
						eraseReq_q <= 1'b0;
						state_q    <= SNV_IDLE;
					end else begin
						wait_q <= wait_q + 32'h0000_0001;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Staging SRAM and nonvolatile array
	// ----------------------------------------
	// Direct writes touch only the staging array, never the active set
	always_ff @(posedge ref_clk) begin
		if (clkEn) begin
			if (state_q == SNV_COMMIT && !isProtected(idx_q) && int'(idx_q) < ACT_WORDS) begin
				sramMem[idx_q[AW-1:0]] <= activeMem[idx_q[ACW-1:0]];
			end else if (wrEn && hit(regReq.addr, `SNV_OFS_WRBYTE) && state_q == SNV_IDLE) begin
				sramMem[ptr_q[AW-1:0]] <= regReq.wdata;
			end
			if (state_q == SNV_ERASE) begin
				nvMem[idx_q[AW-1:0]] <= `SNV_ERASE_BYTE;
			end else if (state_q == SNV_PROGRAM) begin
				nvMem[idx_q[AW-1:0]] <= sramMem[idx_q[AW-1:0]];
			end
		end
	end

	// ----------------------------------------
	// Active registers and power-on overlay
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (clkEn) begin
			if (porPulse && overlay_q) begin
				for (int i = 0; i < ACT_WORDS; i++) begin
					activeMem[i] <= nvMem[i];
				end
			end else if (actWr) begin
				activeMem[actAddr[ACW-1:0]] <= actWdata;
			end
		end
	end

	// Program tally counts good programs at the following power-on
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			tally_q <= 8'h00;
		end else if (clkEn && porPulse && progDone_q) begin
			tally_q <= tally_q + 8'h01;
		end
	end

	// ----------------------------------------
	// Read port and registered outputs
	// ----------------------------------------
	logic [7:0] rdMux;
	always_comb begin
		rdMux = 8'h00;
		unique case (regReq.addr)
			`SNV_OFS_TALLY:    rdMux = tally_q;
			`SNV_OFS_OVERLAY:  rdMux = {overlay_q, 7'h00};
			`SNV_OFS_NVCTRL:   rdMux = {1'b0, commit_q, 3'h0, busyNow, eraseReq_q, 1'b0};
			`SNV_OFS_PTR_HIGH: rdMux = {3'h0, ptr_q[12:8]};
			`SNV_OFS_PTR_LOW:  rdMux = ptr_q[7:0];
			`SNV_OFS_UNLOCK:   rdMux = unlock_q;
			default:           rdMux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			regRsp     <= '0;
			busyOut    <= 1'b0;
			overlayOut <= 1'b0;
			actRdata   <= 8'h00;
		end else if (clkEn) begin
			regRsp.valid <= regReq.rd;
			regRsp.rdata <= rdMux;
			busyOut      <= busyNow;
			overlayOut   <= overlay_q;
			actRdata     <= activeMem[actAddr[ACW-1:0]];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_trigger;
		clkEn && ctrlWr && keyOk && regReq.wdata[`SNV_BIT_PROG]
			&& regReq.wdata[`SNV_BIT_ERASE] && state_q == SNV_IDLE;
	endsequence

	a_lock_blocks: assert property (@(posedge ref_clk) disable iff (!rstn)
		clkEn && ctrlWr && !keyOk && !regReq.wdata[`SNV_BIT_COMMIT] && state_q == SNV_IDLE
		|=> state_q == SNV_IDLE)
		else $error("program started while locked");

	a_erase_first: assert property (@(posedge ref_clk) disable iff (!rstn)
		s_trigger |=> state_q == SNV_ERASE)
		else $error("combined trigger did not erase first");

	a_busy_follows: assert property (@(posedge ref_clk) disable iff (!rstn)
		s_trigger |=> ##1 busyOut)
		else $error("busy not raised after trigger");

	a_commit_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
		$fell(commit_q) |-> state_q == SNV_IDLE && $past(state_q) == SNV_COMMIT)
		else $error("commit bit cleared mid copy");

	a_commit_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
		clkEn && ctrlWr && regReq.wdata[`SNV_BIT_COMMIT] && state_q == SNV_IDLE
		|=> commit_q && state_q == SNV_COMMIT)
		else $error("commit not started");

	a_tally_step: assert property (@(posedge ref_clk) disable iff (!rstn)
		clkEn && porPulse && progDone_q |=> tally_q == $past(tally_q) + 8'h01)
		else $error("tally did not advance");

	a_overlay_bit: assert property (@(posedge ref_clk) disable iff (!rstn)
		clkEn && wrEn && hit(regReq.addr, `SNV_OFS_OVERLAY)
		|=> ##1 overlayOut == $past(regReq.wdata[`SNV_BIT_OVERLAY], 2))
		else $error("overlay bit not applied");

	a_ptr_load: assert property (@(posedge ref_clk) disable iff (!rstn)
		clkEn && wrEn && hit(regReq.addr, `SNV_OFS_PTR_LOW) |=> ptr_q[7:0] == $past(regReq.wdata))
		else $error("pointer low not loaded");

	a_data_store: assert property (@(posedge ref_clk) disable iff (!rstn)
		wrEn && hit(regReq.addr, `SNV_OFS_WRBYTE) && state_q == SNV_IDLE
		|=> sramMem[$past(ptr_q[AW-1:0])] == $past(regReq.wdata))
		else $error("data byte not stored at pointer");

	a_commit_guard: assert property (@(posedge ref_clk) disable iff (!rstn)
		clkEn && state_q == SNV_COMMIT
		|=> $stable(sramMem[PROTECT_LO]) && $stable(sramMem[PROTECT_HI]))
		else $error("commit touched a protected staging word");

	a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
		!clkEn |=> $stable(state_q) && $stable(tally_q) && $stable(unlock_q))
		else $error("state moved while clock enable low");
endmodule // snv_sequencer

// ---- pkg/snv_params.svh ----
// Register offsets, field positions, reset values and timing counts of the image sequencer
`ifndef SNV_PARAMS_SVH
`define SNV_PARAMS_SVH
`define SNV_OFS_TALLY      15'h0010
`define SNV_OFS_OVERLAY    15'h0014
`define SNV_OFS_NVCTRL     15'h00AB
`define SNV_OFS_PTR_HIGH   15'h00AD
`define SNV_OFS_PTR_LOW    15'h00AE
`define SNV_OFS_WRBYTE     15'h00B0
`define SNV_OFS_UNLOCK     15'h00B4
`define SNV_BIT_PROG       0
`define SNV_BIT_ERASE      1
`define SNV_BIT_BUSY       2
`define SNV_BIT_COMMIT     6
`define SNV_BIT_OVERLAY    7
`define SNV_UNLOCK_KEY     8'hEA
`define SNV_RESET_BYTE     8'h00
`define SNV_ERASE_BYTE     8'hFF
`define SNV_CLK_HZ         10000000
`define SNV_BUSY_MS        500
`define SNV_BUSY_CYCLES    ((`SNV_CLK_HZ / 1000) * `SNV_BUSY_MS)
`endif

// ---- pkg/snv_pkg.sv ----
// Types shared by the image sequencer and its users
package snv_pkg;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [14:0] addr;
		logic [7:0]  wdata;
	} snv_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] rdata;
	} snv_rsp_t;

	typedef enum logic [2:0] {
		SNV_IDLE,
		SNV_COMMIT,
		SNV_ERASE,
		SNV_PROGRAM,
		SNV_SETTLE
	} snv_state_t;
endpackage

// ---- dv/snv_host_model.sv ----
// Host model issuing register writes and reads on the request port
`timescale 1ns/1ps
module snv_host_model (
	input  wire logic              ref_clk,
	output snv_pkg::snv_req_t      regReq,
	input  wire snv_pkg::snv_rsp_t regRsp
);
	import snv_pkg::*;
	initial regReq = '0;
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// One-cycle write strobe; a free edge follows so strobes never collide
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		regReq <= '0;
	endtask
	// Read strobe; data taken in whichever of the next two cycles shows valid
	task automatic rd(input logic [14:0] a, output logic [7:0] d);
		d = 8'hxx;
		@(posedge ref_clk);
		regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		regReq <= '0;
		#1 if (regRsp.valid) d = regRsp.rdata;
		@(posedge ref_clk);
		#1 if (regRsp.valid) d = regRsp.rdata;
	endtask
endmodule // snv_host_model

// ---- dv/snv_sequencer_bench.sv ----
// Self-checking bench for the staging image sequencer
`timescale 1ns/1ps
module snv_sequencer_bench;
	import snv_pkg::*;
	localparam int MW = 64;
	localparam int BC = 8;
	logic       ref_clk, rstn, clkEn, porPulse, actWr, busyOut, overlayOut;
	logic [7:0] actAddr, actWdata, actRdata, rv;
	snv_req_t   regReq;
	snv_rsp_t   regRsp;
	int         mismatches, n_tests, cyc;

	snv_sequencer #(.BUSY_CYCLES(BC)) u_snv_sequencer (.ref_clk(ref_clk), .rstn(rstn),
		.clkEn(clkEn), .porPulse(porPulse), .regReq(regReq), .regRsp(regRsp),
		.actWr(actWr), .actAddr(actAddr), .actWdata(actWdata), .actRdata(actRdata),
		.busyOut(busyOut), .overlayOut(overlayOut));
	snv_host_model u_snv_host_model (.ref_clk(ref_clk), .regReq(regReq), .regRsp(regRsp));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Power-on event: a single-cycle pulse
	task automatic por();
		@(posedge ref_clk) porPulse <= 1'b1;
		@(posedge ref_clk) porPulse <= 1'b0;
	endtask
	// Polls a control bit until clear; bounded so a stuck bit ends the run
	task automatic poll_clear(input int b);
		cyc = 0;
		do begin
			u_snv_host_model.rd(15'h00AB, rv);
			cyc++;
		end while (rv[b] !== 1'b0 && cyc < 200);
		if (cyc >= 200) begin
			mismatches++;
			$display("BAD %0t poll timed out", $time);
			report_and_stop();
		end
	endtask
	// Counts cycles while busy stands; a stuck flag ends the run
	task automatic busy_len(output int n);
		n = 0;
		while (busyOut === 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			#1 n++;
		end
		if (n >= 1000) begin
			mismatches++;
			$display("BAD %0t busy never cleared", $time);
			report_and_stop();
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		por();
		u_snv_host_model.rd(15'h0010, rv);
		check(rv, 8'h00, "tally without program");
		u_snv_host_model.rd(15'h01FF, rv);
		check(rv, 8'h00, "unmapped read");
	endtask
	// Wrong key: a combined trigger must be ignored
	task automatic t_locked();
		u_snv_host_model.wr(15'h00B4, 8'hE9);
		u_snv_host_model.wr(15'h00AB, 8'h03);
		repeat (3) @(posedge ref_clk);
		#1 check({7'h0, busyOut}, 8'h00, "busy with wrong key");
	endtask
	// Staging writes through the pointer must leave active settings alone
	task automatic t_direct();
		@(posedge ref_clk) actWr <= 1'b1;
		@(posedge ref_clk) begin
			actAddr  <= 8'h0C;
			actWdata <= 8'h77;
		end
		@(posedge ref_clk) actWr <= 1'b0;
		u_snv_host_model.wr(15'h00AD, 8'h00);
		u_snv_host_model.wr(15'h00AE, 8'h0C);
		u_snv_host_model.wr(15'h00B0, 8'h19);
		u_snv_host_model.wr(15'h00AE, 8'h0D);
		u_snv_host_model.wr(15'h00B0, 8'h03);
		#1 check(actRdata, 8'h77, "active reg disturbed");
		@(posedge ref_clk) actAddr <= 8'h05;
	endtask
	task automatic t_commit();
		u_snv_host_model.wr(15'h00AB, 8'h40);
		poll_clear(6);
		check({7'h0, busyOut}, 8'h00, "busy after commit");
		// Change the live setting so the overlay load can be told apart later
		@(posedge ref_clk) begin
			actWdata <= 8'h33;
			actWr    <= 1'b1;
		end
		@(posedge ref_clk) actWr <= 1'b0;
		u_snv_host_model.wr(15'h0014, 8'h80);
		u_snv_host_model.rd(15'h0014, rv);
		check(rv, 8'h80, "overlay bit");
		check({7'h0, overlayOut}, 8'h01, "overlay out");
	endtask
	// Unlock, combined trigger, busy span, relock, tally step
	task automatic t_program();
		u_snv_host_model.wr(15'h00B4, 8'hEA);
		u_snv_host_model.wr(15'h00AB, 8'h03);
		repeat (2) @(posedge ref_clk);
		#1 check({7'h0, busyOut}, 8'h01, "busy not raised");
		busy_len(cyc);
		check(8'(cyc > 2 * MW + BC - 6 && cyc < 2 * MW + BC + 6), 8'h01, "busy span");
		poll_clear(2);
		u_snv_host_model.wr(15'h00B4, 8'h00);
		por();
		u_snv_host_model.rd(15'h0010, rv);
		check(rv, 8'h01, "tally step");
		check(actRdata, 8'h5A, "overlay load");
		@(posedge ref_clk) actAddr <= 8'h0C;
		@(posedge ref_clk);
		#1 check(actRdata, 8'h19, "protected byte kept");
	endtask
	// With the clock enable low a register write must be lost
	task automatic t_freeze();
		@(posedge ref_clk) clkEn <= 1'b0;
		u_snv_host_model.wr(15'h0014, 8'h00);
		@(posedge ref_clk) clkEn <= 1'b1;
		u_snv_host_model.rd(15'h0014, rv);
		check(rv, 8'h80, "write while frozen");
	endtask
	// Relocked triggers are refused; a lone program trigger skips the erase
	task automatic t_prog_only();
		u_snv_host_model.wr(15'h00AB, 8'h03);
		repeat (3) @(posedge ref_clk);
		#1 check({7'h0, busyOut}, 8'h00, "busy after relock");
		u_snv_host_model.wr(15'h00B4, 8'hEA);
		u_snv_host_model.wr(15'h00AB, 8'h01);
		repeat (2) @(posedge ref_clk);
		#1 check({7'h0, busyOut}, 8'h01, "busy on program only");
		busy_len(cyc);
		check(8'(cyc > MW + BC - 6 && cyc < MW + BC + 6), 8'h01, "program only span");
		u_snv_host_model.wr(15'h00B4, 8'h00);
		por();
		u_snv_host_model.rd(15'h0010, rv);
		check(rv, 8'h02, "second tally step");
	endtask

	// ----------------------------------------
	// Clock, reset and main sequence
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		rstn = 1'b0;
		clkEn = 1'b1;
		porPulse = 1'b0;
		actWr = 1'b0;
		actAddr = 8'h05;
		actWdata = 8'h5A;
		mismatches = 0;
		n_tests = 0;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		#1 check({6'h0, busyOut, overlayOut}, 8'h00, "outputs after reset");
		t_reset();
		t_locked();
		t_direct();
		t_commit();
		t_freeze();
		t_program();
		t_prog_only();
		report_and_stop();
	end
endmodule // snv_sequencer_bench
